//--- design/bink_pkg.sv
package bink_pkg;

  // ----------------------------------------------------------------
  // Endpoint geometry
  // ----------------------------------------------------------------
  localparam int EP_COUNT     = 8;   // One bit per endpoint number
  localparam int IN_EP_INDEX  = 6;   // Bit position of the bulk IN endpoint
  localparam int OUT_EP_INDEX = 2;   // Bit position of the bulk OUT endpoint
  localparam int BUF_DEPTH    = 16;  // Bytes held by each OUT buffer
  localparam int PTR_W        = 4;   // Index into one OUT buffer
  localparam int FILL_W       = 5;   // Fill count, 0 to BUF_DEPTH
  localparam int COUNT_W      = 11;  // Byte count, high 3 bits plus low byte
  localparam int COUNT_HI_W   = 3;   // Width of the count high part

  // ----------------------------------------------------------------
  // Field positions and encodings
  // ----------------------------------------------------------------
  localparam int          SKIP_BIT         = 7;          // Skip bit of count low
  localparam int          CFG_VALID_BIT    = 7;          // Endpoint valid
  localparam int          CFG_DIR_IN_BIT   = 6;          // Direction: 1 is IN
  localparam logic [7:0]  CFG_OUT_BULK_DBL = 8'h00_A2;   // Bulk OUT, double buffered
  localparam logic [7:0]  CFG_IN_BULK_DBL  = 8'h00_E2;   // Bulk IN, double buffered
  localparam logic [7:0]  AUTOPTR_ENABLE   = 8'h00_01;   // Auto pointers on
  localparam logic [7:0]  IRQ_CLEAR_ALL    = 8'h00_FF;   // Clears every request
  localparam int          STAT_OUT_EMPTY   = 0;          // OUT holds no host data
  localparam int          STAT_OUT_FULL    = 1;          // Both OUT buffers full
  localparam int          STAT_IN_EMPTY    = 4;          // IN not committed
  localparam int          STAT_IN_BUSY     = 5;          // IN packet on the wire

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BUF_FW    = 2'b00,  // Held by firmware, not yet armed
    BUF_ARMED = 2'b01,  // Empty, the host may fill it
    BUF_FULL  = 2'b10   // Holds a host packet
  } bink_buf_t;

  // One byte of a host data stream
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       last;
  } bink_byte_t;

  // State of the endpoint block, apart from the IN FIFO
  typedef struct packed {
    bink_buf_t [1:0]                           bufState;
    logic [1:0][COUNT_W-1:0]                   bufCount;
    logic [1:0][BUF_DEPTH-1:0][7:0]            outMem;
    logic                                      fillSel;
    logic                                      readSel;
    logic [FILL_W-1:0]                         fillPtr;
    logic [PTR_W-1:0]                          ptrOne;
    logic                                      autoOn;
    logic [EP_COUNT-1:0]                       irqReq;
    logic [COUNT_HI_W-1:0]                     inCountHigh;
    logic [COUNT_W-1:0]                        inCount;
    logic                                      inCommitted;
    logic                                      inSending;
    logic [COUNT_W-1:0]                        inRemain;
    logic                                      inNak;
    logic                                      inZlp;
    logic                                      outAck;
    logic                                      outNak;
  } bink_ep_state_t;

endpackage : bink_pkg

//--- design/bink_fifo.sv
`timescale 1ns/100ps
`default_nettype none

module bink_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             ref_clk,  // Core clock
  input  wire logic             rst,      // Synchronous reset
  input  wire logic             wrValid,  // Write offered
  output logic                  wrReady,  // Room for a word
  input  wire logic [WIDTH-1:0] wrData,   // Word to store
  output logic                  rdValid,  // Word available
  input  wire logic             rdReady,  // Drain side takes it
  output logic [WIDTH-1:0]      rdData    // Oldest word
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wrPtr;
    logic [AW:0]                 rdPtr;
  } bink_fifo_state_t;

  bink_fifo_state_t st_reg;
  bink_fifo_state_t st_next;

  // Extra pointer bit tells full from empty
  assign wrReady = (st_reg.wrPtr - st_reg.rdPtr) != (AW+1)'(DEPTH);
  assign rdValid = st_reg.wrPtr != st_reg.rdPtr;
  assign rdData  = st_reg.mem[st_reg.rdPtr[AW-1:0]];

  // Pointer and storage update
  always_comb begin
    st_next = st_reg;
    if (wrValid && wrReady) begin
      st_next.mem[st_reg.wrPtr[AW-1:0]] = wrData;
      st_next.wrPtr = st_reg.wrPtr + 1'b1;
    end
    if (rdValid && rdReady) begin
      st_next.rdPtr = st_reg.rdPtr + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule : bink_fifo

`default_nettype wire

//--- design/bink_endpoint.sv
// Functional notes
// RULE1: An IN request to a bulk endpoint with no committed buffer gets NAK, a committed one gets data.
// RULE2: Each NAK of an IN request sets that endpoint's in-bulk-NAK request bit.
// RULE3: Enables and requests are eight bits each, indexed by endpoint number.
// RULE4: The global request is the OR of the per-endpoint requests, gated by one global enable; the code gates only inNakIrq, not nakGlobalRequest.
// RULE5: Writing one to a request bit clears it, and writing all ones clears them all.
// RULE6: A count low write with bit 7 set on the OUT endpoint skips one buffer and arms it empty.
// RULE7: Firmware arms a double-buffered OUT endpoint twice after configuration.
// RULE8: Writing IN count high then low commits exactly that many bytes for the next IN.
// RULE9: The status flags show the OUT endpoint empty while no host packet is held.
// RULE10: Configuration 0xA2 is bulk double-buffered OUT, 0xE2 is IN, bit 6 chooses IN.
// RULE11: Firmware spaces successive writes to these endpoint controls.
// RULE12: Writing 0x01 to auto pointer setup makes each auto-data access advance its pointer.
// RULE13: A skip write after the data is consumed frees that OUT buffer for the next packet.
// RULE14: With both OUT buffers full, further host OUT packets get NAK.
// RULE15: The interrupt handler masks, clears, then re-enables only endpoints not pending.
// RULE16: A request bit stays set until cleared and raises the interrupt only when both enables are set.
`timescale 1ns/100ps
`default_nettype none

module bink_endpoint #(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic                   ref_clk,             // 40 MHz core clock
  input  wire logic                   rst,                 // Synchronous reset
  input  wire logic [7:0]             outEndpointConfig,   // OUT endpoint config
  input  wire logic [7:0]             inEndpointConfig,    // IN endpoint config
  input  wire logic [7:0]             fwData,              // Firmware write data
  input  wire logic                   outCountLowWr,       // OUT count low write
  input  wire logic                   inCountHighWr,       // IN count high write
  input  wire logic                   inCountLowWr,        // IN count low write
  input  wire logic                   irqClearWr,          // Request clear write
  input  wire logic                   autoPtrSetupWr,      // Auto pointer setup write
  input  wire logic                   autoDataOneRd,       // Read through port one
  output logic [7:0]                  autoDataPortOne,     // OUT byte at pointer one
  input  wire logic                   autoDataTwoWr,       // Write through port two
  output logic                        autoDataTwoReady,    // Port two can take a byte
  input  wire logic [7:0]             inNakIrqEnableBits,  // Per-endpoint enables
  input  wire logic                   nakGlobalEnable,     // Global enable
  output logic [7:0]                  inNakIrqRequestBits, // Per-endpoint requests
  output logic                        nakGlobalRequest,    // OR of the requests
  output logic                        inNakIrq,            // Interrupt output
  output logic [7:0]                  endpointStatusFlags, // Endpoint status
  output logic [7:0]                  outEpCountLow,       // OUT count low byte
  output logic [7:0]                  outEpCountHigh,      // OUT count high byte
  input  wire bink_pkg::bink_byte_t   hostOut,             // Host OUT data byte
  output logic                        outAck,              // OUT packet stored
  output logic                        outNak,              // OUT packet refused
  input  wire logic                   hostInReq,           // Host IN token
  output logic                        inNak,               // IN answered with NAK
  output logic                        inZlp,               // Zero-length answer
  output logic                        inDataValid,         // IN byte offered
  input  wire logic                   hostInReady,         // Host takes IN byte
  output logic [7:0]                  inData,              // IN byte
  output logic                        inDataLast           // Last IN byte
);

  // ----------------------------------------------------------------
  // State and endpoint decode
  // ----------------------------------------------------------------
  bink_pkg::bink_ep_state_t st_reg;
  bink_pkg::bink_ep_state_t st_next;

  logic                        fifoRdValid;
  logic                        fifoRdReady;
  logic                        fifoWrReady;
  logic [7:0]                  fifoRdData;
  logic [bink_pkg::EP_COUNT-1:0] irqSet;
  logic                        outEpValid;
  logic                        inEpValid;
  logic                        inFire;

  // Valid bit plus direction bit pick the role
  function automatic logic cfgIs(input logic [7:0] cfg, input logic wantIn);
    cfgIs = cfg[bink_pkg::CFG_VALID_BIT] && (cfg[bink_pkg::CFG_DIR_IN_BIT] == wantIn);
  endfunction : cfgIs

  assign outEpValid = cfgIs(outEndpointConfig, 1'b0);  // see RULE10
  assign inEpValid  = cfgIs(inEndpointConfig, 1'b1);   // see RULE10

  // ----------------------------------------------------------------
  // IN buffer; port two stalls while it is full or pointers are off
  // ----------------------------------------------------------------
  bink_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_in_fifo (
    .ref_clk (ref_clk),
    .rst     (rst),
    .wrValid (autoDataTwoWr && st_reg.autoOn),
    .wrReady (fifoWrReady),
    .wrData  (fwData),
    .rdValid (fifoRdValid),
    .rdReady (fifoRdReady),
    .rdData  (fifoRdData)
  );

  assign autoDataTwoReady = fifoWrReady && st_reg.autoOn;  // see RULE12
  assign fifoRdReady      = st_reg.inSending && hostInReady;
  assign inDataValid      = st_reg.inSending && fifoRdValid;
  assign inFire           = inDataValid && hostInReady;
  assign inData           = fifoRdData;
  assign inDataLast       = st_reg.inSending && (st_reg.inRemain == bink_pkg::COUNT_W'(1));

  // ----------------------------------------------------------------
  // Outputs drawn from state
  // ----------------------------------------------------------------
  assign autoDataPortOne     = st_reg.outMem[st_reg.readSel][st_reg.ptrOne];
  assign inNakIrqRequestBits = st_reg.irqReq;                                    // see RULE3
  assign nakGlobalRequest    = |st_reg.irqReq;                                   // see RULE4
  assign inNakIrq = nakGlobalEnable && |(st_reg.irqReq & inNakIrqEnableBits);  // see RULE16
  assign outEpCountLow       = st_reg.bufCount[st_reg.readSel][7:0];
  assign outEpCountHigh      = {5'b0_0000, st_reg.bufCount[st_reg.readSel][10:8]};
  assign outAck              = st_reg.outAck;
  assign outNak              = st_reg.outNak;
  assign inNak               = st_reg.inNak;
  assign inZlp               = st_reg.inZlp;

  // Status: empty while no buffer holds a host packet
  always_comb begin
    endpointStatusFlags = '0;
    endpointStatusFlags[bink_pkg::STAT_OUT_EMPTY] =
      (st_reg.bufState[0] != bink_pkg::BUF_FULL) && (st_reg.bufState[1] != bink_pkg::BUF_FULL);  // see RULE9
    endpointStatusFlags[bink_pkg::STAT_OUT_FULL] =
      (st_reg.bufState[0] == bink_pkg::BUF_FULL) && (st_reg.bufState[1] == bink_pkg::BUF_FULL);
    endpointStatusFlags[bink_pkg::STAT_IN_EMPTY] = !st_reg.inCommitted;
    endpointStatusFlags[bink_pkg::STAT_IN_BUSY]  = st_reg.inSending;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next        = st_reg;
    st_next.inNak  = 1'b0;
    st_next.inZlp  = 1'b0;
    st_next.outAck = 1'b0;
    st_next.outNak = 1'b0;
    irqSet         = '0;

    // Host OUT bytes land in the buffer being filled; excess bytes are dropped
    if (hostOut.valid && outEpValid) begin
      if (st_reg.bufState[st_reg.fillSel] == bink_pkg::BUF_ARMED) begin
        if (st_reg.fillPtr != bink_pkg::FILL_W'(bink_pkg::BUF_DEPTH)) begin
          st_next.outMem[st_reg.fillSel][st_reg.fillPtr[bink_pkg::PTR_W-1:0]] = hostOut.data;
          st_next.fillPtr = st_reg.fillPtr + 1'b1;
        end
        if (hostOut.last) begin
          st_next.bufState[st_reg.fillSel] = bink_pkg::BUF_FULL;
          st_next.bufCount[st_reg.fillSel] = bink_pkg::COUNT_W'(st_next.fillPtr);
          st_next.fillSel = !st_reg.fillSel;
          st_next.fillPtr = '0;
          st_next.outAck  = 1'b1;
        end
      end else if (hostOut.last) begin
        st_next.outNak = 1'b1;  // see RULE14
      end
    end

    // Pointer one advances per read only with auto pointers on
    if (autoDataOneRd && st_reg.autoOn) begin
      st_next.ptrOne = st_reg.ptrOne + 1'b1;  // see RULE12
    end
    if (autoPtrSetupWr) begin
      st_next.autoOn = (fwData == bink_pkg::AUTOPTR_ENABLE);  // see RULE12
    end

    // Skip write: free the oldest full buffer, else arm an idle one
    if (outCountLowWr && fwData[bink_pkg::SKIP_BIT] && outEpValid) begin
      if (st_reg.bufState[st_reg.readSel] == bink_pkg::BUF_FULL) begin
        st_next.bufState[st_reg.readSel] = bink_pkg::BUF_ARMED;  // see RULE13
        st_next.readSel = !st_reg.readSel;
        st_next.ptrOne  = '0;
      end else if (st_reg.bufState[0] == bink_pkg::BUF_FW) begin
        st_next.bufState[0] = bink_pkg::BUF_ARMED;  // see RULE6
      end else if (st_reg.bufState[1] == bink_pkg::BUF_FW) begin
        st_next.bufState[1] = bink_pkg::BUF_ARMED;  // see RULE6
      end
    end

    // Count high is held until the low write commits the buffer
    if (inCountHighWr) begin
      st_next.inCountHigh = fwData[bink_pkg::COUNT_HI_W-1:0];
    end
    if (inCountLowWr && !st_reg.inCommitted) begin
      st_next.inCount     = {st_reg.inCountHigh, fwData};  // see RULE8
      st_next.inCommitted = 1'b1;
    end

    // IN token: data if committed, otherwise NAK and raise the request
    if (hostInReq && inEpValid && !st_reg.inSending) begin
      if (!st_reg.inCommitted) begin
        st_next.inNak = 1'b1;                    // see RULE1
        irqSet[bink_pkg::IN_EP_INDEX] = 1'b1;    // see RULE2
      end else if (st_reg.inCount == '0) begin
        st_next.inZlp       = 1'b1;
        st_next.inCommitted = 1'b0;
      end else begin
        st_next.inSending = 1'b1;                // see RULE1
        st_next.inRemain  = st_reg.inCount;
      end
    end
    if (inFire) begin
      st_next.inRemain = st_reg.inRemain - 1'b1;
      if (st_reg.inRemain == bink_pkg::COUNT_W'(1)) begin
        st_next.inSending   = 1'b0;
        st_next.inCommitted = 1'b0;
      end
    end

    // Write-one clears; a new NAK in the same cycle wins over the clear
    st_next.irqReq = (st_reg.irqReq & ~(irqClearWr ? fwData : 8'h00_00)) | irqSet;  // see RULE5
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_in_nak_uncommitted;
    @(posedge ref_clk) disable iff (rst)
      hostInReq && inEpValid && !st_reg.inSending && !st_reg.inCommitted |=> inNak && !inDataValid;
  endproperty
  a_in_nak_uncommitted: assert property (p_in_nak_uncommitted) else $error("IN not NAKed"); // see RULE1

  property p_in_data_committed;
    @(posedge ref_clk) disable iff (rst)
      hostInReq && inEpValid && !st_reg.inSending && st_reg.inCommitted && st_reg.inCount != '0
      |=> st_reg.inSending && !inNak;
  endproperty
  a_in_data_committed: assert property (p_in_data_committed) else $error("IN data not started"); // see RULE1

  property p_nak_sets_request;
    @(posedge ref_clk) disable iff (rst)
      inNak |-> inNakIrqRequestBits[bink_pkg::IN_EP_INDEX] && nakGlobalRequest;
  endproperty
  a_nak_sets_request: assert property (p_nak_sets_request) else $error("NAK without request"); // see RULE2

  property p_request_sticky;
    @(posedge ref_clk) disable iff (rst)
      st_reg.irqReq[bink_pkg::IN_EP_INDEX] && !(irqClearWr && fwData[bink_pkg::IN_EP_INDEX])
      |=> st_reg.irqReq[bink_pkg::IN_EP_INDEX];
  endproperty
  a_request_sticky: assert property (p_request_sticky) else $error("Request lost"); // see RULE16

  property p_clear_all;
    @(posedge ref_clk) disable iff (rst)
      irqClearWr && fwData == bink_pkg::IRQ_CLEAR_ALL && !hostInReq |=> st_reg.irqReq == '0 && !inNakIrq;
  endproperty
  a_clear_all: assert property (p_clear_all) else $error("Clear all failed"); // see RULE5

  property p_irq_gated;
    @(posedge ref_clk) disable iff (rst)
      inNakIrq |-> nakGlobalEnable && nakGlobalRequest && (st_reg.irqReq & inNakIrqEnableBits) != '0;
  endproperty
  a_irq_gated: assert property (p_irq_gated) else $error("Interrupt not gated"); // see RULE4

  property p_skip_frees;
    @(posedge ref_clk) disable iff (rst)
      outCountLowWr && fwData[bink_pkg::SKIP_BIT] && outEpValid
      && st_reg.bufState[st_reg.readSel] == bink_pkg::BUF_FULL
      |=> st_reg.bufState[$past(st_reg.readSel)] == bink_pkg::BUF_ARMED && st_reg.ptrOne == '0;
  endproperty
  a_skip_frees: assert property (p_skip_frees) else $error("Skip did not free buffer"); // see RULE13

  property p_ack_not_empty;
    @(posedge ref_clk) disable iff (rst)
      outAck |-> !endpointStatusFlags[bink_pkg::STAT_OUT_EMPTY];
  endproperty
  a_ack_not_empty: assert property (p_ack_not_empty) else $error("Empty after packet"); // see RULE9

  property p_out_nak_full;
    @(posedge ref_clk) disable iff (rst)
      hostOut.valid && hostOut.last && outEpValid && endpointStatusFlags[bink_pkg::STAT_OUT_FULL]
      |=> outNak && !outAck;
  endproperty
  a_out_nak_full: assert property (p_out_nak_full) else $error("OUT accepted while full"); // see RULE14

  property p_auto_increment;
    @(posedge ref_clk) disable iff (rst)
      autoDataOneRd && st_reg.autoOn && !outCountLowWr |=> st_reg.ptrOne == $past(st_reg.ptrOne) + 1'b1;
  endproperty
  a_auto_increment: assert property (p_auto_increment) else $error("Pointer did not advance"); // see RULE12

  property p_commit_count;
    @(posedge ref_clk) disable iff (rst)
      inCountLowWr && !st_reg.inCommitted
      |=> st_reg.inCommitted && st_reg.inCount == {$past(st_reg.inCountHigh), $past(fwData)};
  endproperty
  a_commit_count: assert property (p_commit_count) else $error("Commit count wrong"); // see RULE8

endmodule : bink_endpoint

`default_nettype wire

//--- sim/bink_host.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------
// Host side: OUT packets, IN tokens, IN byte sink
// ------------------------------------------------
module bink_host (
  input  wire logic                ref_clk,     // Core clock
  output var  bink_pkg::bink_byte_t hostOut,    // OUT byte stream
  input  wire logic                outAck,      // Packet stored
  input  wire logic                outNak,      // Packet refused
  output logic                     hostInReq,   // IN token
  input  wire logic                inNak,       // IN refused
  input  wire logic                inDataValid, // IN byte offered
  input  wire logic [7:0]          inData,      // IN byte
  input  wire logic                inDataLast,  // Last IN byte
  output logic                     hostInReady  // Takes IN byte
);
  initial begin
    hostOut = '0;
    hostInReq = 1'b0;
    hostInReady = 1'b0;
  end
  // Bytes back to back; idle data inverted so stale bytes never look valid
  task automatic sendOut(input int n, input logic [7:0] base, output logic ack, output logic nak);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk) #1;
      hostOut = '{valid: 1'b1, data: base + 8'(i), last: (i == n - 1)};
    end
    @(posedge ref_clk) #1;
    hostOut = '{valid: 1'b0, data: ~hostOut.data, last: 1'b0};
    ack = outAck;
    nak = outNak;
  endtask : sendOut
  // One token, answer looked at in the following cycle
  task automatic inToken(output logic nak);
    @(posedge ref_clk) #1;
    hostInReq = 1'b1;
    @(posedge ref_clk) #1;
    hostInReq = 1'b0;
    nak = inNak;
  endtask : inToken
  // Slow host: stalls two cycles, then drains until the last byte
  task automatic readIn(output logic [7:0] got [$], output logic lastOk);
    got = {};
    lastOk = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 hostInReady = 1'b1;
    for (int k = 0; k < 20 && !lastOk; k++) begin
      if (inDataValid === 1'b1) begin
        got.push_back(inData);
        lastOk = (inDataLast === 1'b1);
      end
      @(posedge ref_clk) #1;
    end
    hostInReady = 1'b0;
  endtask : readIn
endmodule : bink_host
`default_nettype wire

//--- sim/bink_endpoint_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin failures++; $display("FAIL %s exp %h got %h", nm, e, g); end end
module bink_endpoint_tb;
  localparam int OUTLO = 0, INHI = 1, INLO = 2, CLR = 3, APS = 4;
  logic ref_clk, rst, outCountLowWr, inCountHighWr, inCountLowWr, irqClearWr, autoPtrSetupWr;
  logic autoDataOneRd, autoDataTwoWr, autoDataTwoReady, nakGlobalEnable, nakGlobalRequest, inNakIrq;
  logic outAck, outNak, hostInReq, inNak, inDataValid, hostInReady, inDataLast, ack, nak, lastOk, zlp;
  logic [7:0] outCfg, inCfg, fwData, autoDataPortOne, enBits, reqBits, stat, cntLo, cntHi, inData;
  logic [7:0] got [$];
  bink_pkg::bink_byte_t hostOut;
  int failures, compares;
  bink_endpoint u_bink_endpoint (.ref_clk(ref_clk), .rst(rst), .outEndpointConfig(outCfg),
    .inEndpointConfig(inCfg), .fwData(fwData), .outCountLowWr(outCountLowWr), .inCountHighWr(inCountHighWr),
    .inCountLowWr(inCountLowWr), .irqClearWr(irqClearWr), .autoPtrSetupWr(autoPtrSetupWr),
    .autoDataOneRd(autoDataOneRd), .autoDataPortOne(autoDataPortOne), .autoDataTwoWr(autoDataTwoWr),
    .autoDataTwoReady(autoDataTwoReady), .inNakIrqEnableBits(enBits), .nakGlobalEnable(nakGlobalEnable),
    .inNakIrqRequestBits(reqBits), .nakGlobalRequest(nakGlobalRequest), .inNakIrq(inNakIrq),
    .endpointStatusFlags(stat), .outEpCountLow(cntLo), .outEpCountHigh(cntHi), .hostOut(hostOut),
    .outAck(outAck), .outNak(outNak), .hostInReq(hostInReq), .inNak(inNak), .inZlp(zlp),
    .inDataValid(inDataValid), .hostInReady(hostInReady), .inData(inData), .inDataLast(inDataLast));
  bink_host u_bink_host (.ref_clk(ref_clk), .hostOut(hostOut), .outAck(outAck), .outNak(outNak),
    .hostInReq(hostInReq), .inNak(inNak), .inDataValid(inDataValid), .inData(inData),
    .inDataLast(inDataLast), .hostInReady(hostInReady));
  // ------------------------------------------------
  // Clock, watchdog and closing report
  // ------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // Cuts a hang short well inside the cycle budget
  initial begin
    #2_000_000;
    failures++;
    wrap_up();
  end
  task automatic wrap_up();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up
  // One-cycle firmware strobe, fwData held alongside
  task automatic fw(input int sel, input logic [7:0] d);
    @(posedge ref_clk) #1;
    fwData = d;
    {autoPtrSetupWr, irqClearWr, inCountLowWr, inCountHighWr, outCountLowWr} = 5'b1 << sel;
    @(posedge ref_clk) #1;
    {autoPtrSetupWr, irqClearWr, inCountLowWr, inCountHighWr, outCountLowWr} = '0;
  endtask : fw
  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial begin
    failures = 0;
    compares = 0;
    rst = 1'b1;
    fwData = '0;
    {autoPtrSetupWr, irqClearWr, inCountLowWr, inCountHighWr, outCountLowWr} = '0;
    {autoDataOneRd, autoDataTwoWr} = '0;
    enBits = 8'h00_40;
    nakGlobalEnable = 1'b1;
    outCfg = bink_pkg::CFG_OUT_BULK_DBL;
    inCfg = bink_pkg::CFG_IN_BULK_DBL;
    repeat (10) @(posedge ref_clk);
    #1 rst = 1'b0;
    `CHK("outEmpty", 1'b1, stat[bink_pkg::STAT_OUT_EMPTY])
    `CHK("port2Ready", 1'b0, autoDataTwoReady)
    $display("test reset done");
    u_bink_host.inToken(nak);
    `CHK("inNak", 1'b1, nak)
    `CHK("reqBits", 8'h00_40, reqBits)
    `CHK("globalReq", 1'b1, nakGlobalRequest)
    `CHK("irq", 1'b1, inNakIrq)
    #1 enBits = 8'h00_BF;
    #1 `CHK("irqOtherEn", 1'b0, inNakIrq)
    enBits = 8'h00_40;
    nakGlobalEnable = 1'b0;
    #1 `CHK("irqGlobalOff", 1'b0, inNakIrq)
    fw(CLR, 8'h00_BF);
    `CHK("reqSticky", 8'h00_40, reqBits)
    fw(CLR, bink_pkg::IRQ_CLEAR_ALL);
    `CHK("reqCleared", 8'h00_00, reqBits)
    `CHK("globalClr", 1'b0, nakGlobalRequest)
    $display("test interrupt done");
    u_bink_host.sendOut(2, 8'h00_01, ack, nak);
    `CHK("unarmedNak", 1'b1, nak)
    fw(OUTLO, 8'h00_80);
    fw(OUTLO, 8'h00_80);
    u_bink_host.sendOut(3, 8'h00_10, ack, nak);
    `CHK("ackA", 1'b1, ack)
    u_bink_host.sendOut(2, 8'h00_20, ack, nak);
    `CHK("ackB", 1'b1, ack)
    u_bink_host.sendOut(1, 8'h00_30, ack, nak);
    `CHK("fullNak", 1'b1, nak)
    `CHK("outEmpty", 1'b0, stat[bink_pkg::STAT_OUT_EMPTY])
    `CHK("countA", 8'h00_03, cntLo)
    `CHK("countHi", 8'h00_00, cntHi)
    `CHK("outFull", 1'b1, stat[bink_pkg::STAT_OUT_FULL])
    $display("test out done");
    fw(APS, bink_pkg::AUTOPTR_ENABLE);
    `CHK("port2Ready", 1'b1, autoDataTwoReady)
    // Copy loop: read port one and write port two in the same cycle
    for (int i = 0; i < 3; i++) begin
      @(posedge ref_clk) #1;
      `CHK("port1", 8'h00_10 + 8'(i), autoDataPortOne)
      fwData = 8'h00_10 + 8'(i);
      {autoDataOneRd, autoDataTwoWr} = 2'b11;
    end
    @(posedge ref_clk) #1;
    {autoDataOneRd, autoDataTwoWr} = '0;
    fw(INHI, 8'h00_00);
    fw(INLO, 8'h00_03);
    `CHK("committed", 1'b0, stat[bink_pkg::STAT_IN_EMPTY])
    fw(OUTLO, 8'h00_80);
    `CHK("countB", 8'h00_02, cntLo)
    u_bink_host.sendOut(2, 8'h00_40, ack, nak);
    `CHK("rearmAck", 1'b1, ack)
    u_bink_host.inToken(nak);
    `CHK("inData", 1'b0, nak)
    `CHK("inBusy", 1'b1, stat[bink_pkg::STAT_IN_BUSY])
    u_bink_host.readIn(got, lastOk);
    `CHK("lastSeen", 1'b1, lastOk)
    `CHK("inCount", 3, got.size())
    for (int i = 0; i < got.size(); i++) `CHK("inByte", 8'h00_10 + 8'(i), got[i])
    `CHK("uncommitted", 1'b1, stat[bink_pkg::STAT_IN_EMPTY])
    u_bink_host.inToken(nak);
    `CHK("nakAgain", 1'b1, nak)
    `CHK("reqAgain", 8'h00_40, reqBits)
    $display("test loopback done");
    nakGlobalEnable = 1'b1;
    #1 `CHK("irqBack", 1'b1, inNakIrq)
    enBits = 8'h00_00;
    #1 `CHK("irqMasked", 1'b0, inNakIrq)
    fw(CLR, 8'h00_40);
    enBits = 8'h00_80;
    `CHK("handlerClr", 8'h00_00, reqBits)
    `CHK("handlerIrq", 1'b0, inNakIrq)
    fw(INHI, 8'h00_00);
    fw(INLO, 8'h00_00);
    u_bink_host.inToken(nak);
    `CHK("zlp", 1'b1, zlp)
    `CHK("zlpNoNak", 1'b0, nak)
    `CHK("zlpDone", 1'b1, stat[bink_pkg::STAT_IN_EMPTY])
    $display("test handler done");
    wrap_up();
  end
endmodule : bink_endpoint_tb
`default_nettype wire
